// *** logic/cec_hyst_dec.sv ***
// decodes the positive and negative hysteresis selects into taps.
// assumes the selects come from registers on the same clock.
`default_nettype none

module cec_hyst_dec (
   input  wire cec_pkg::cec_hyst_sel_t pos_sel,
   input  wire cec_pkg::cec_hyst_sel_t neg_sel,
   output cec_pkg::cec_tap_t           pos_tap,
   output cec_pkg::cec_tap_t           neg_tap
);
   import cec_pkg::*;

   // one shared decode keeps both sides on identical encodings
   assign pos_tap = hyst_tap(pos_sel);
   assign neg_tap = hyst_tap(neg_sel);

endmodule

`default_nettype wire

// *** logic/cec_sync.sv ***
// two-flop synchroniser for the asynchronous comparator output.
// assumes sys_clk, synchronous active-high rst and a clock enable.
`default_nettype none

module cec_sync (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic async_in,
   output logic      sync_out
);
   import cec_pkg::*;

   typedef struct packed {
      logic s1;
      logic s2;
   } cec_sync_state_t;

   cec_sync_state_t st_reg;
   cec_sync_state_t st_next;

   // first stage feeds only the second stage
   always_comb begin
      st_next = st_reg;
      if (ce) begin
         st_next.s1 = async_in;
         st_next.s2 = st_reg.s1;
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sync_out = st_reg.s2;

endmodule

`default_nettype wire

// *** logic/cec_top.sv ***
// comparator edge control: control and mode registers, synchronised
// comparator output, sticky edge flags and the interrupt request.
// assumes an 8-bit sfr port on sys_clk, interrupt enables from the
// interrupt controller on the same clock, and an asynchronous
// comparator output from the analog core.
`default_nettype none

// Summary of operation
// - both output edges raise separate events
// - falling edge sets flag bit 4
// - rising edge sets flag bit 5
// - flags sticky until software writes zero
// - rising flag forwarded only when enabled
// - falling flag forwarded only when enabled
// - bit 6 reads live comparator result
// - bit 7 turns comparator on or off
// - bits 3:2 select positive hysteresis
// - bits 1:0 select negative hysteresis
// - mode register selects response time
// - spurious edges after power-up or changes
// - flags set regardless of interrupt enables
module cec_top (
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic              cmp_raw,
   input  wire logic              rise_irq_enable,
   input  wire logic              fall_irq_enable,
   input  wire cec_pkg::cec_byte_t sfr_addr,
   input  wire logic              sfr_wr,
   input  wire logic              sfr_rd,
   input  wire cec_pkg::cec_byte_t sfr_wdata,
   output cec_pkg::cec_byte_t     sfr_rdata,
   output logic                   cmp_enable,
   output cec_pkg::cec_tap_t      pos_hyst_tap,
   output cec_pkg::cec_tap_t      neg_hyst_tap,
   output cec_pkg::cec_mode_t     resp_mode,
   output logic                   cmp_irq
);
   import cec_pkg::*;

   // state of the block apart from the synchroniser, control fields first
   typedef struct packed {
      logic      en;
      logic      rif;
      logic      fif;
      logic [1:0] hyp;
      logic [1:0] hyn;
      cec_mode_t mode;
      logic      prev;
      cec_byte_t rdata;
      logic      irq;
      cec_tap_t  ptap;
      cec_tap_t  ntap;
   } cec_top_state_t;

   localparam cec_top_state_t ST_RST = {
      CTRL_RST[EN_BIT],
      CTRL_RST[RIF_BIT],
      CTRL_RST[FIF_BIT],
      CTRL_RST[HYP_HI:HYP_LO],
      CTRL_RST[HYN_HI:HYN_LO],
      MODE_RST,
      1'h0,
      RDATA_RST,
      1'h0,
      TAP_NONE,
      TAP_NONE
   };

   cec_top_state_t st_reg;
   cec_top_state_t st_next;
   logic           cmp_sync;
   cec_tap_t       ptap_dec;
   cec_tap_t       ntap_dec;
   logic           rise_det;
   logic           fall_det;
   logic           ctrl_wr;
   logic           mode_wr;

   // comparator output into the clock domain
   cec_sync u_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .ce       (ce),
      .async_in (cmp_raw),
      .sync_out (cmp_sync)
   );

   // hysteresis select decode
   cec_hyst_dec u_dec (
      .pos_sel (st_reg.hyp),
      .neg_sel (st_reg.hyn),
      .pos_tap (ptap_dec),
      .neg_tap (ntap_dec)
   );

   // sfr write decode
   assign ctrl_wr = sfr_wr && (sfr_addr == CTRL_ADDR);
   assign mode_wr = sfr_wr && (sfr_addr == MODE_ADDR);

   // edge detection on synchronised samples, only while powered;
   // settling glitches right after enable or a setting change are
   // recorded like real edges and left to software to discard
   assign rise_det = st_reg.en && cmp_sync && !st_reg.prev;
   assign fall_det = st_reg.en && !cmp_sync && st_reg.prev;

   // next-state logic, frozen while ce is low
   always_comb begin
      st_next = st_reg;
      if (ce) begin
         st_next.prev = cmp_sync;
         // control register write
         if (ctrl_wr) begin
            st_next.en  = sfr_wdata[EN_BIT];
            st_next.rif = sfr_wdata[RIF_BIT];
            st_next.fif = sfr_wdata[FIF_BIT];
            st_next.hyp = sfr_wdata[HYP_HI:HYP_LO];
            st_next.hyn = sfr_wdata[HYN_HI:HYN_LO];
         end
         // response time mode write
         if (mode_wr) begin
            st_next.mode = sfr_wdata[MODE_HI:MODE_LO];
         end
         // an edge wins over a clear in the same cycle
         if (rise_det) begin
            st_next.rif = 1'h1;
         end
         if (fall_det) begin
            st_next.fif = 1'h1;
         end
         // analog taps follow the stored selects
         st_next.ptap = ptap_dec;
         st_next.ntap = ntap_dec;
         // masked flags onto one request
         st_next.irq = (st_next.rif && rise_irq_enable) ||
                       (st_next.fif && fall_irq_enable);
         // read data, pre-write view of the registers
         if (sfr_rd) begin
            if (sfr_addr == CTRL_ADDR) begin
               st_next.rdata = {st_reg.en, cmp_sync, st_reg.rif,
                                st_reg.fif, st_reg.hyp,
                                st_reg.hyn};
            end else if (sfr_addr == MODE_ADDR) begin
               st_next.rdata = {6'h00, st_reg.mode};
            end else begin
               st_next.rdata = UNMAPPED;
            end
         end
      end
   end

   // state register, reset wins over ce
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_reg <= ST_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from flip-flops
   assign sfr_rdata    = st_reg.rdata;
   assign cmp_enable   = st_reg.en;
   assign pos_hyst_tap = st_reg.ptap;
   assign neg_hyst_tap = st_reg.ntap;
   assign resp_mode    = st_reg.mode;
   assign cmp_irq      = st_reg.irq;

   // checks on the block's own behaviour
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // a control write followed by an enabled cycle
   sequence s_ctrl_write;
      ce && ctrl_wr;
   endsequence

   sequence s_settle;
      s_ctrl_write ##1 ce;
   endsequence

   // an edge seen by the detector while the block runs
   sequence s_rise_seen;
      ce && rise_det;
   endsequence

   sequence s_fall_seen;
      ce && fall_det;
   endsequence

   // edge flags: set by hardware, held until software writes
   a_rise_sets_flag: assert property (
      s_rise_seen |=> st_reg.rif)
      else $error("rising edge did not set its flag");

   a_fall_sets_flag: assert property (
      s_fall_seen |=> st_reg.fif)
      else $error("falling edge did not set its flag");

   a_rise_sticky: assert property (
      st_reg.rif && !(ce && ctrl_wr) |=> st_reg.rif)
      else $error("rising flag dropped without a software write");

   a_fall_sticky: assert property (
      st_reg.fif && !(ce && ctrl_wr) |=> st_reg.fif)
      else $error("falling flag dropped without a software write");

   a_flag_no_enable: assert property (
      ce && rise_det && !rise_irq_enable |=> st_reg.rif)
      else $error("masked rising edge was not recorded");

   a_rise_masked: assert property (
      ce && !fall_irq_enable |=>
      cmp_irq == ($past(rise_irq_enable) && st_reg.rif))
      else $error("rising request not gated by its enable");

   a_fall_masked: assert property (
      ce && !rise_irq_enable |=>
      cmp_irq == ($past(fall_irq_enable) && st_reg.fif))
      else $error("falling request not gated by its enable");

   a_irq_or_term: assert property (
      ce |=> cmp_irq == (($past(rise_irq_enable) && st_reg.rif) ||
                         ($past(fall_irq_enable) && st_reg.fif)))
      else $error("request is not the or of masked flags");

   a_out_bit_read: assert property (
      ce && sfr_rd && sfr_addr == CTRL_ADDR |=>
      sfr_rdata[OUT_BIT] == $past(cmp_sync))
      else $error("output state bit does not show comparator");

   a_enable_write: assert property (
      s_ctrl_write |=> cmp_enable == $past(sfr_wdata[EN_BIT]))
      else $error("enable bit did not follow the write");

   a_pos_hyst_tap: assert property (
      s_settle |=>
      pos_hyst_tap == hyst_tap($past(sfr_wdata[HYP_HI:HYP_LO], 2)))
      else $error("positive hysteresis tap wrong");

   a_neg_hyst_tap: assert property (
      s_settle |=>
      neg_hyst_tap == hyst_tap($past(sfr_wdata[HYN_HI:HYN_LO], 2)))
      else $error("negative hysteresis tap wrong");

   a_mode_write: assert property (
      ce && mode_wr |=> resp_mode == $past(sfr_wdata[MODE_HI:MODE_LO]))
      else $error("response mode did not follow the write");

   a_sync_latency: assert property (
      ce && $past(ce) && $past(ce, 2) && !$past(rst, 2) &&
      !$past(rst) |->
      cmp_sync == $past(cmp_raw, 2))
      else $error("synchroniser latency is not two cycles");

   // a falling edge must never show up as a rising one
   a_edges_separate: assert property (
      ce && fall_det && !st_reg.rif && !ctrl_wr |=> !st_reg.rif)
      else $error("falling edge set the rising flag");

   // software clears, lost only to a same-cycle edge
   a_rise_clear: assert property (
      ce && ctrl_wr && !sfr_wdata[RIF_BIT] && !rise_det |=> !st_reg.rif)
      else $error("rising flag not cleared by a zero write");

   a_fall_clear: assert property (
      ce && ctrl_wr && !sfr_wdata[FIF_BIT] && !fall_det |=> !st_reg.fif)
      else $error("falling flag not cleared by a zero write");

   // a powered-down comparator records no edges
   a_no_edge_off: assert property (
      ce && !st_reg.en && !ctrl_wr |=>
      $stable(st_reg.rif) && $stable(st_reg.fif))
      else $error("edge flag moved while comparator is off");

   a_irq_quiet: assert property (
      ce && !rise_irq_enable && !fall_irq_enable |=> !cmp_irq)
      else $error("request raised with both enables low");

   // register port: read data view and hold
   a_ctrl_read: assert property (
      ce && sfr_rd && sfr_addr == CTRL_ADDR |=>
      sfr_rdata[EN_BIT] == $past(st_reg.en) &&
      sfr_rdata[RIF_BIT] == $past(st_reg.rif) &&
      sfr_rdata[FIF_BIT] == $past(st_reg.fif))
      else $error("control register read does not match state");

   a_mode_read: assert property (
      ce && sfr_rd && sfr_addr == MODE_ADDR |=>
      sfr_rdata == {6'h00, $past(resp_mode)})
      else $error("mode register read does not match state");

   a_unmapped_read: assert property (
      ce && sfr_rd && sfr_addr != CTRL_ADDR && sfr_addr != MODE_ADDR |=>
      sfr_rdata == UNMAPPED)
      else $error("unmapped read did not return zero");

   a_rdata_hold: assert property (
      !(ce && sfr_rd) |=> $stable(sfr_rdata))
      else $error("read data changed without a read");

   // clock enable low freezes every register of the block
   a_ce_freeze: assert property (
      !ce |=> $stable(st_reg))
      else $error("state moved while clock enable was low");

endmodule

`default_nettype wire

// *** shared/cec_pkg.sv ***
// package for the comparator edge control block: register offsets,
// field positions, reset values, hysteresis encodings and tap codes.
// assumes an 8-bit special-function-register port on sys_clk.
`default_nettype none

package cec_pkg;

   // byte and field types
   typedef logic [7:0] cec_byte_t;
   typedef logic [1:0] cec_hyst_sel_t;
   typedef logic [2:0] cec_tap_t;
   typedef logic [1:0] cec_mode_t;

   // register offsets on the sfr port
   localparam cec_byte_t CTRL_ADDR = 8'h9B;
   localparam cec_byte_t MODE_ADDR = 8'h9D;

   // control register field positions
   localparam int EN_BIT  = 7;
   localparam int OUT_BIT = 6;
   localparam int RIF_BIT = 5;
   localparam int FIF_BIT = 4;
   localparam int HYP_HI  = 3;
   localparam int HYP_LO  = 2;
   localparam int HYN_HI  = 1;
   localparam int HYN_LO  = 0;

   // mode register field position
   localparam int MODE_HI = 1;
   localparam int MODE_LO = 0;

   // reset values
   localparam cec_byte_t CTRL_RST  = 8'h00;
   localparam cec_mode_t MODE_RST  = 2'h0;
   localparam cec_byte_t RDATA_RST = 8'h00;
   localparam cec_byte_t UNMAPPED  = 8'h00;

   // hysteresis select encodings
   localparam cec_hyst_sel_t HYS_OFF  = 2'h0;
   localparam cec_hyst_sel_t HYS_5MV  = 2'h1;
   localparam cec_hyst_sel_t HYS_10MV = 2'h2;
   localparam cec_hyst_sel_t HYS_20MV = 2'h3;

   // one-hot analog tap codes, all zero means no hysteresis
   localparam cec_tap_t TAP_NONE = 3'h0;
   localparam cec_tap_t TAP_5MV  = 3'h1;
   localparam cec_tap_t TAP_10MV = 3'h2;
   localparam cec_tap_t TAP_20MV = 3'h4;

   // maps a hysteresis select onto its analog tap
   function automatic cec_tap_t hyst_tap(input cec_hyst_sel_t sel);
      cec_tap_t t;
      t = TAP_NONE;
      case (sel)
         HYS_OFF:  t = TAP_NONE;
         HYS_5MV:  t = TAP_5MV;
         HYS_10MV: t = TAP_10MV;
         HYS_20MV: t = TAP_20MV;
         default:  t = TAP_NONE;
      endcase
      return t;
   endfunction

endpackage

`default_nettype wire

// *** tb/cec_cmp_model.sv ***
// behavioural analog comparator core with its two input pins.
// assumes input levels in mV driven by the bench.
`default_nettype none
module cec_cmp_model
   import cec_pkg::*;
(
   input  var int            pos_mv,
   input  var int            neg_mv,
   input  wire logic         enable,
   input  wire cec_tap_t     pos_tap,
   input  wire cec_tap_t     neg_tap,
   input  wire cec_mode_t    mode,
   output logic              out_raw
);
   timeunit 1ns;
   timeprecision 1ps;

   // tap code to millivolts
   function automatic int tap_mv(input cec_tap_t t);
      case (t)
         3'h1:    return 5;
         3'h2:    return 10;
         3'h4:    return 20;
         default: return 0;
      endcase
   endfunction

   initial out_raw = 1'b0;

   // slower modes answer later; hysteresis holds the last state
   always begin
      @(pos_mv or neg_mv or enable or pos_tap or neg_tap or mode);
      #(10 * (mode + 1));
      if (!enable) begin
         out_raw = 1'b0;
      end else if (pos_mv > neg_mv + tap_mv(pos_tap)) begin
         out_raw = 1'b1;
      end else if (pos_mv < neg_mv - tap_mv(neg_tap)) begin
         out_raw = 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** tb/comparator_edge_control_tb_top.sv ***
// self-checking bench for the comparator edge control block.
// assumes the comparator model feeds cmp_raw from bench levels.
`default_nettype none
module comparator_edge_control_tb_top
   import cec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic       sys_clk, rst, ce, rise_ie, fall_ie, sfr_wr, sfr_rd;
   logic       cmp_raw, cmp_enable, cmp_irq;
   cec_byte_t  sfr_addr, sfr_wdata, sfr_rdata, d;
   cec_tap_t   pos_tap, neg_tap;
   cec_mode_t  resp_mode;
   int         pos_mv, neg_mv, fail_count, check_count;

   cec_top u_dut (
      .sys_clk(sys_clk), .rst(rst), .ce(ce), .cmp_raw(cmp_raw),
      .rise_irq_enable(rise_ie), .fall_irq_enable(fall_ie),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .cmp_enable(cmp_enable), .pos_hyst_tap(pos_tap),
      .neg_hyst_tap(neg_tap), .resp_mode(resp_mode), .cmp_irq(cmp_irq));

   cec_cmp_model u_model (
      .pos_mv(pos_mv), .neg_mv(neg_mv), .enable(cmp_enable),
      .pos_tap(pos_tap), .neg_tap(neg_tap), .mode(resp_mode),
      .out_raw(cmp_raw));

   // 40 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic give_verdict;
      if (fail_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one write strobe, taken at the next edge
   task automatic wr(input cec_byte_t a, input cec_byte_t v);
      @(posedge sys_clk);
      sfr_addr  <= a;
      sfr_wdata <= v;
      sfr_wr    <= 1'b1;
      @(posedge sys_clk);
      sfr_wr <= 1'b0;
   endtask

   // read, mask and compare
   task automatic rc(input cec_byte_t a, input cec_byte_t m,
                     input cec_byte_t e);
      @(posedge sys_clk);
      sfr_addr <= a;
      sfr_rd   <= 1'b1;
      @(posedge sys_clk);
      sfr_rd <= 1'b0;
      @(posedge sys_clk);
      chk(sfr_rdata & m, e);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // bounded wait for the comparator, then synchroniser latency
   task automatic wait_raw(input logic v);
      for (int i = 0; i < 40 && cmp_raw !== v; i++) tick(1);
      if (cmp_raw !== v) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, cmp_raw, v);
         give_verdict();
      end
      tick(4);
   endtask

   function automatic cec_tap_t oh(input int v);
      return (v == 0) ? 3'h0 : 3'(1 << (v - 1));
   endfunction

   task automatic t_reset;
      rc(CTRL_ADDR, 8'hFF, 8'h00);
      rc(MODE_ADDR, 8'hFF, 8'h00);
      rc(8'h55, 8'hFF, 8'h00);
      chk({cmp_enable, cmp_irq, pos_tap, neg_tap}, 8'h00);
      chk({6'h0, resp_mode}, 8'h00);
   endtask

   // every hysteresis code and response mode
   task automatic t_config;
      for (int s = 0; s < 4; s++) begin
         wr(CTRL_ADDR, {4'h8, s[1:0], 2'(3 - s)});
         tick(2);
         chk({2'h0, pos_tap, neg_tap}, {2'h0, oh(s), oh(3 - s)});
         chk({7'h0, cmp_enable}, 8'h01);
         rc(CTRL_ADDR, 8'hBF, {4'h8, s[1:0], 2'(3 - s)});
         wr(MODE_ADDR, 8'(s));
         rc(MODE_ADDR, 8'hFF, 8'(s));
         chk({6'h0, resp_mode}, 8'(s));
      end
      wr(8'h9C, 8'hFF);
      rc(CTRL_ADDR, 8'hBF, 8'h8C);
      wr(CTRL_ADDR, 8'h00);
      tick(2);
      chk({7'h0, cmp_enable}, 8'h00);
   endtask

   // strobes are ignored while the clock enable is low
   task automatic t_ce;
      @(posedge sys_clk);
      ce <= 1'b0;
      wr(CTRL_ADDR, 8'h8F);
      rc(MODE_ADDR, 8'hFF, 8'h8C);
      @(posedge sys_clk);
      ce <= 1'b1;
      rc(CTRL_ADDR, 8'hFF, 8'h00);
   endtask

   task automatic t_edges;
      wr(CTRL_ADDR, 8'h80);
      wr(MODE_ADDR, 8'h00);
      pos_mv <= 100;
      neg_mv <= 200;
      tick(8);
      wr(CTRL_ADDR, 8'h80);
      pos_mv <= 300;
      wait_raw(1'b1);
      rc(CTRL_ADDR, 8'hFF, 8'hE0);
      chk({7'h0, cmp_irq}, 8'h00);
      rise_ie <= 1'b1;
      tick(2);
      chk({7'h0, cmp_irq}, 8'h01);
      pos_mv <= 100;
      wait_raw(1'b0);
      rc(CTRL_ADDR, 8'hFF, 8'hB0);
      wr(CTRL_ADDR, 8'h90);
      tick(2);
      chk({7'h0, cmp_irq}, 8'h00);
      rc(CTRL_ADDR, 8'hFF, 8'h90);
      fall_ie <= 1'b1;
      tick(2);
      chk({7'h0, cmp_irq}, 8'h01);
      wr(CTRL_ADDR, 8'h80);
      tick(2);
      chk({7'h0, cmp_irq}, 8'h00);
   endtask

   // reset in mid-run clears settings, flags and the request
   task automatic t_mid_reset;
      wr(MODE_ADDR, 8'h02);
      wr(CTRL_ADDR, 8'hBF);
      tick(2);
      chk({7'h0, cmp_irq}, 8'h01);
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      chk(sfr_rdata, 8'h00);
      rc(CTRL_ADDR, 8'hFF, 8'h00);
      rc(MODE_ADDR, 8'hFF, 8'h00);
      chk({cmp_enable, cmp_irq, pos_tap, neg_tap}, 8'h00);
   endtask

   // reset, then the scenarios in turn
   initial begin
      {rst, ce} = 2'b11;
      {rise_ie, fall_ie, sfr_wr, sfr_rd} = 4'h0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      {pos_mv, neg_mv, fail_count, check_count} = '0;
      tick(8);
      rst <= 1'b0;
      t_reset();
      t_config();
      t_ce();
      t_edges();
      t_mid_reset();
      give_verdict();
   end
endmodule
`default_nettype wire
